// ---- design/odr_filter.sv ----
// outlier detect-and-replace filter with its output fifo
// assumes samples and config come from logic on clk_in; ce_in low freezes everything
`timescale 1ns/10ps

// output buffer, flip-flop storage with honest full and empty
module odr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,
    input  wire logic             srst_in,
    input  wire logic             ce_in,
    input  wire logic             wr_valid_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  wr_ready_out,
    output logic                  rd_valid_out,
    output logic [WIDTH-1:0]      rd_data_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        not_full;
        logic                        not_empty;
    } odr_fifo_s;
    odr_fifo_s s;
    odr_fifo_s next_s;
    logic      wr;
    logic      rd;

    // handshakes, gated by the clock enable
    assign wr = ce_in && wr_valid_in && s.not_full;
    assign rd = ce_in && s.not_empty && rd_ready_in;
    assign wr_ready_out = s.not_full;
    assign rd_valid_out = s.not_empty;
    assign rd_data_out  = s.mem[s.rp];

    // pointer and count update
    always_comb begin
        next_s = s;
        if (wr) begin
            next_s.mem[s.wp] = wr_data_in;
            next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + AW'(1);
        end
        if (rd) begin
            next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + AW'(1);
        end
        next_s.cnt       = s.cnt + (AW+1)'(wr) - (AW+1)'(rd);
        next_s.not_full  = next_s.cnt != (AW+1)'(DEPTH);
        next_s.not_empty = next_s.cnt != '0;
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s <= '0;
            s.not_full <= 1'b1;
        end else if (ce_in) begin
            s <= next_s;
        end
    end
endmodule

// the filter itself
module odr_filter #(
    parameter logic [odr_pkg::SAMPLE_W-1:0] INIT_BASE = 19'h00010
) (
    input  wire logic                          clk_in,
    input  wire logic                          srst_in,
    input  wire logic                          ce_in,
    input  wire logic                          cfg_wr_in,
    input  wire logic                          cfg_rd_in,
    input  wire logic [7:0]                    cfg_addr_in,
    input  wire logic [7:0]                    cfg_wdata_in,
    output logic      [7:0]                    cfg_rdata_out,
    input  wire logic                          in_valid_in,
    input  wire logic [odr_pkg::SAMPLE_W-1:0]  in_sample_in,
    output logic                               in_ready_out,
    output logic                               out_valid_out,
    output odr_pkg::odr_sample_s               out_sample_out,
    input  wire logic                          out_ready_in
);
    import odr_pkg::*;

    typedef struct packed {
        logic [7:0]                   cfg;
        logic [7:0]                   rdata;
        odr_state_e                   st;
        logic [3:0][SAMPLE_W-1:0]     hist;
        logic [SAMPLE_W-1:0]          lpf;
        logic                         ovalid;
        odr_sample_s                  odata;
    } odr_top_s;
    odr_top_s s;
    odr_top_s next_s;

    logic                       fifo_ready;
    logic                       fifo_valid;
    odr_sample_s                fifo_data;
    logic                       pop;
    logic                       acc_c;
    logic signed [SAMPLE_W+2:0] fit_c;
    logic [SAMPLE_W-1:0]        pred_c;
    logic [SAMPLE_W-1:0]        diff_c;
    logic [TH_W-1:0]            thr_c;
    logic                       outlier_c;
    logic [SAMPLE_W-1:0]        out_val_c;
    logic [2:0]                 tc_sh;
    logic [2:0]                 gain_sh;
    logic [SAMPLE_W-1:0]        init_c;

    assign acc_c = ce_in && in_valid_in && fifo_ready;
    assign pop   = fifo_valid && (!s.ovalid || out_ready_in);

    // line fit extrapolation, (2*newest + second newest - oldest) / 2, clamped to range
    assign fit_c = (SAMPLE_W+3)'({s.hist[0], 1'b0}) + (SAMPLE_W+3)'(s.hist[1])
                 - (SAMPLE_W+3)'(s.hist[3]);
    always_comb begin
        pred_c = s.hist[0];
        if (s.cfg[ORDER_BIT]) begin
            if (fit_c < 0) begin
                pred_c = '0;
            end else if (fit_c[SAMPLE_W+1]) begin
                pred_c = '1;
            end else begin
                pred_c = fit_c[SAMPLE_W:1];
            end
        end
    end

    assign diff_c = (in_sample_in > pred_c) ? in_sample_in - pred_c : pred_c - in_sample_in;
    assign gain_sh = 3'(GAIN_BASE_SHIFT) + {1'b0, s.cfg[GAIN_LSB +: 2]};
    assign thr_c   = TH_W'(s.lpf) << gain_sh;
    assign outlier_c = (s.st == ST_RUN) && s.cfg[EN_BIT] && (TH_W'(diff_c) > thr_c);
    assign out_val_c = outlier_c ? pred_c : in_sample_in;
    // constant 8 to 64 samples as shift 3 to 6
    assign tc_sh  = 3'(TC_BASE_SHIFT) + {1'b0, s.cfg[TC_LSB +: 2]};
    assign init_c = INIT_BASE << s.cfg[INIT_LSB +: 2];

    // config port, state sequencing, history and filter update
    always_comb begin
        next_s = s;
        if (cfg_wr_in && cfg_addr_in == CFG_ADDR) begin
            next_s.cfg = cfg_wdata_in;
        end
        if (cfg_rd_in) begin
            next_s.rdata = (cfg_addr_in == CFG_ADDR) ? s.cfg : 8'h00;
        end
        // leave or enter the algorithm with the enable bit
        case (s.st)
            ST_OFF: begin
                if (s.cfg[EN_BIT]) begin
                    next_s.st = ST_PRIME;
                end
            end
            ST_PRIME: begin
                if (!s.cfg[EN_BIT]) begin
                    next_s.st = ST_OFF;
                end else if (acc_c) begin
                    next_s.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!s.cfg[EN_BIT]) begin
                    next_s.st = ST_OFF;
                end
            end
            default: next_s.st = ST_OFF;
        endcase
        if (acc_c) begin
            next_s.hist = {s.hist[2:0], out_val_c};
            if (s.st == ST_PRIME) begin
                // history and filter loaded on start
                next_s.hist = {4{in_sample_in}};
                next_s.lpf  = init_c;
            end else if (s.st == ST_RUN) begin
                if (diff_c >= s.lpf) begin
                    next_s.lpf = s.lpf + ((diff_c - s.lpf) >> tc_sh);
                end else begin
                    next_s.lpf = s.lpf - ((s.lpf - diff_c) >> tc_sh);
                end
            end
        end
        if (pop) begin
            next_s.ovalid = 1'b1;
            next_s.odata  = fifo_data;
        end else if (out_ready_in) begin
            next_s.ovalid = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s <= '0;
            s.cfg <= CFG_RESET;
            s.st <= ST_OFF;
        end else if (ce_in) begin
            s <= next_s;
        end
    end

    odr_fifo #(
        .WIDTH ($bits(odr_sample_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in       (clk_in),
        .srst_in      (srst_in),
        .ce_in        (ce_in),
        .wr_valid_in  (in_valid_in),
        .wr_data_in   ({out_val_c, outlier_c}),
        .wr_ready_out (fifo_ready),
        .rd_valid_out (fifo_valid),
        .rd_data_out  (fifo_data),
        .rd_ready_in  (!s.ovalid || out_ready_in)
    );

    assign in_ready_out   = fifo_ready;
    assign cfg_rdata_out  = s.rdata;
    assign out_valid_out  = s.ovalid;
    assign out_sample_out = s.odata;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    property p_off_quiet;
        acc_c && !s.cfg[EN_BIT] |=> s.hist[0] == $past(in_sample_in);
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("replace while disabled");
    property p_diff;
        acc_c |-> ((in_sample_in > pred_c)
                   ? ({1'b0, pred_c} + {1'b0, diff_c} == {1'b0, in_sample_in})
                   : ({1'b0, in_sample_in} + {1'b0, diff_c} == {1'b0, pred_c}));
    endproperty
    a_diff: assert property (p_diff) else $error("bad error magnitude");
    property p_detect;
        acc_c && s.st == ST_RUN && s.cfg[EN_BIT] && TH_W'(diff_c) > thr_c |-> outlier_c;
    endproperty
    a_detect: assert property (p_detect) else $error("outlier missed");
    property p_replace;
        acc_c && s.st == ST_RUN
            |=> s.hist[0] == ($past(outlier_c) ? $past(pred_c) : $past(in_sample_in));
    endproperty
    a_replace: assert property (p_replace) else $error("wrong value passed");
    property p_prev;
        !s.cfg[ORDER_BIT] |-> pred_c == s.hist[0];
    endproperty
    a_prev: assert property (p_prev) else $error("order 0 prediction wrong");
    property p_flat_fit;
        s.cfg[ORDER_BIT] && s.hist[0] == s.hist[1] && s.hist[1] == s.hist[2]
            && s.hist[2] == s.hist[3] |-> pred_c == s.hist[0];
    endproperty
    a_flat_fit: assert property (p_flat_fit) else $error("fit of flat history wrong");
    property p_gain4;
        s.cfg[GAIN_LSB +: 2] == 2'h0 |-> thr_c == {3'h0, s.lpf, 2'h0};
    endproperty
    a_gain4: assert property (p_gain4) else $error("gain 4 wrong");
    property p_gain32;
        s.cfg[GAIN_LSB +: 2] == 2'h3 |-> thr_c == {s.lpf, 5'h00};
    endproperty
    a_gain32: assert property (p_gain32) else $error("gain 32 wrong");
    property p_tc8;
        acc_c && s.st == ST_RUN && s.cfg[TC_LSB +: 2] == 2'h0 && diff_c >= s.lpf
            |=> s.lpf == $past(s.lpf) + (($past(diff_c) - $past(s.lpf)) >> 3);
    endproperty
    a_tc8: assert property (p_tc8) else $error("filter step wrong");
    property p_init;
        acc_c && s.st == ST_PRIME |=> s.lpf == (INIT_BASE << $past(s.cfg[INIT_LSB +: 2]));
    endproperty
    a_init: assert property (p_init) else $error("filter init wrong");
    property p_tc_range;
        tc_sh >= 3'd3 && tc_sh <= 3'd6;
    endproperty
    a_tc_range: assert property (p_tc_range) else $error("time constant out of range");

    c_out0: cover property (acc_c && outlier_c && !s.cfg[ORDER_BIT]);
    c_out1: cover property (acc_c && outlier_c && s.cfg[ORDER_BIT]);
    c_full: cover property (!fifo_ready);
    c_pass: cover property (out_valid_out && out_ready_in && !out_sample_out.replaced);
endmodule

// ---- design/odr_pkg.sv ----
// constants, field layout and carrier types of the outlier detect-and-replace filter
// assumes a single 50 MHz clock domain and a same-clock sample source
// Contract
// - replacement is off after reset and works only while the enable bit 7 of the config is one.
// - each new sample gives an error equal to the magnitude of sample minus prediction.
// - a sample is an outlier when its error is strictly above the current threshold.
// - an outlier is passed on as the prediction, any other sample passes unchanged.
// - with the order bit at zero the prediction is the previous sample.
// - with the order bit at one the prediction is a least-squares line through the last four outputs.
// - the threshold is the low-pass filtered error times the selected gain.
// - gain codes 0 to 3 give 4, 8, 16 and 32 times, code 3 being 32 times.
// - the time-constant field sets the error filter constant between 8 and 64 samples.
// - the init field sets the value loaded into the error filter when the algorithm starts.
package odr_pkg;
    localparam int         SAMPLE_W        = 19;
    localparam logic [7:0] CFG_ADDR        = 8'h16;
    localparam logic [7:0] CFG_RESET       = 8'h00;
    localparam int         EN_BIT          = 7;
    localparam int         ORDER_BIT       = 6;
    localparam int         TC_LSB          = 4;
    localparam int         INIT_LSB        = 2;
    localparam int         GAIN_LSB        = 0;
    localparam int         TC_BASE_SHIFT   = 3;
    localparam int         GAIN_BASE_SHIFT = 2;
    localparam int         TH_W            = SAMPLE_W + 5;
    localparam int         FIFO_DEPTH      = 32;

    typedef enum logic [1:0] {ST_OFF, ST_PRIME, ST_RUN} odr_state_e;

    typedef struct packed {
        logic [SAMPLE_W-1:0] value;
        logic                replaced;
    } odr_sample_s;
endpackage

// ---- test/odr_stream_partner.sv ----
// stream partner of odr_filter: sample source and stallable sink
// assumes send and idle are called at a falling clock edge
`timescale 1ns/10ps
module odr_stream_partner
    import odr_pkg::*;
(
    input  wire logic                    clk_in,
    input  wire logic                    srst_in,
    input  wire logic                    stall_in,
    input  wire logic                    ready_in,
    input  wire logic                    out_valid_in,
    input  wire odr_pkg::odr_sample_s    out_sample_in,
    output logic                         valid_out,
    output logic [odr_pkg::SAMPLE_W-1:0] sample_out,
    output logic                         out_ready_out
);
    odr_sample_s got_q[$];
    initial begin
        valid_out = 1'b0;
        sample_out = '0;
        out_ready_out = 1'b0;
    end
    // sink readiness follows the stall request
    always @(negedge clk_in) begin
        out_ready_out <= ~stall_in;
    end
    // keep every output word that was accepted
    always @(posedge clk_in) begin
        if (!srst_in && out_valid_in && out_ready_out) begin
            got_q.push_back(out_sample_in);
        end
    end
    // hold the sample until ready stood high before a rising edge
    task automatic send(input logic [SAMPLE_W-1:0] v);
        valid_out <= 1'b1;
        sample_out <= v;
        while (ready_in !== 1'b1) @(negedge clk_in);
        @(negedge clk_in);
    endtask
    // released data line shows a changing pattern, not the last value
    task automatic idle();
        valid_out <= 1'b0;
        sample_out <= ~sample_out;
        @(negedge clk_in);
    endtask
endmodule

// ---- test/outlier_detect_replace_filter_tb_top.sv ----
// testbench of odr_filter: config access, pass-through, detection, fifo
// assumes the partner model drives the sample stream and the sink
`timescale 1ns/10ps
module outlier_detect_replace_filter_tb_top;
    import odr_pkg::*;
    logic                clk_in = 1'b0;
    logic                srst_in = 1'b1;
    logic                wr = 1'b0, rd = 1'b0, stall = 1'b0;
    logic [7:0]          addr = 8'h00, wdata = 8'h00, rdata, rv;
    logic                in_valid, in_ready, out_valid, out_ready;
    logic [SAMPLE_W-1:0] in_sample;
    odr_sample_s         out_sample, o;
    int                  failures = 0, cmp_count = 0;
    int                  n, thr, lpf;
    // clock of 20 ns period
    always #10 clk_in = ~clk_in;
    odr_filter u_odr_filter (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
        .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_addr_in(addr), .cfg_wdata_in(wdata),
        .cfg_rdata_out(rdata), .in_valid_in(in_valid), .in_sample_in(in_sample),
        .in_ready_out(in_ready), .out_valid_out(out_valid), .out_sample_out(out_sample),
        .out_ready_in(out_ready));
    odr_stream_partner u_odr_stream_partner (.clk_in(clk_in), .srst_in(srst_in),
        .stall_in(stall), .ready_in(in_ready), .out_valid_in(out_valid),
        .out_sample_in(out_sample), .valid_out(in_valid), .sample_out(in_sample),
        .out_ready_out(out_ready));
    task automatic final_report();
        $display("checks=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk_cfg(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_out(input odr_sample_s g, input int v, input logic r);
        odr_sample_s e;
        e = {v[SAMPLE_W-1:0], r};
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(negedge clk_in);
        wr <= 1'b0;
        @(negedge clk_in);
    endtask
    task automatic cfg_rd(input logic [7:0] a, output logic [7:0] d);
        rd <= 1'b1; addr <= a;
        @(negedge clk_in);
        rd <= 1'b0;
        d = rdata;
        @(negedge clk_in);
    endtask
    // take one output word under a bounded wait
    task automatic get(output odr_sample_s s);
        int w;
        w = 0;
        while (u_odr_stream_partner.got_q.size() == 0 && w < 200) begin
            @(negedge clk_in);
            w++;
        end
        if (u_odr_stream_partner.got_q.size() == 0) begin
            failures++;
            $display("ERROR t=%0t no output word got=%h exp=%h", $time, 1'b0, 1'b1);
            s = '0;
        end else s = u_odr_stream_partner.got_q.pop_front();
    endtask
    // restart the algorithm with cfg, then send a priming and a test sample
    task automatic pair(input logic [7:0] c, input int s0, input int s1,
                        input int ev, input logic er);
        cfg_wr(CFG_ADDR, 8'h00);
        cfg_wr(CFG_ADDR, c);
        u_odr_stream_partner.send(s0[SAMPLE_W-1:0]);
        u_odr_stream_partner.send(s1[SAMPLE_W-1:0]);
        u_odr_stream_partner.idle();
        get(o); chk_out(o, s0, 1'b0);
        get(o); chk_out(o, ev, er);
    endtask
    task automatic t_cfg();
        cfg_rd(CFG_ADDR, rv); chk_cfg(rv, CFG_RESET);
        cfg_wr(CFG_ADDR, 8'h3f);
        cfg_rd(CFG_ADDR, rv); chk_cfg(rv, 8'h3f);
        cfg_wr(8'h17, 8'h55);
        cfg_rd(8'h17, rv); chk_cfg(rv, 8'h00);
        cfg_rd(CFG_ADDR, rv); chk_cfg(rv, 8'h3f);
    endtask
    // enable low: wild jumps pass untouched
    task automatic t_off();
        pair(8'h3f, 1000, 60000, 60000, 1'b0);
    endtask
    // gain and init codes at the threshold edge, both signs of error
    task automatic t_gain();
        for (int g = 0; g < 4; g++) begin
            thr = (16 << g) << (2 + g);
            pair(8'(8'h80 | (g << 2) | g), 10000, 10000 + thr, 10000 + thr, 1'b0);
            pair(8'(8'h80 | (g << 2) | g), 10000, 9999 - thr, 10000, 1'b1);
        end
    endtask
    // time constant decides whether the third sample is replaced
    task automatic t_tc();
        for (int tc = 0; tc < 4; tc++) begin
            lpf = 16 + (48 >> (3 + tc));
            pair(8'(8'h80 | (tc << 4)), 1000, 1064, 1064, 1'b0);
            u_odr_stream_partner.send(19'h0046e);
            u_odr_stream_partner.idle();
            get(o); chk_out(o, (70 > 4 * lpf) ? 1064 : 1134, 70 > 4 * lpf);
        end
    endtask
    // line fit on a ramp, jump replaced by the extrapolated point
    task automatic t_order1();
        pair(8'hcf, 1000, 1010, 1010, 1'b0);
        u_odr_stream_partner.send(19'h003fc);
        u_odr_stream_partner.send(19'h00406);
        u_odr_stream_partner.send(19'h01793);
        u_odr_stream_partner.idle();
        get(o); chk_out(o, 1020, 1'b0);
        get(o); chk_out(o, 1030, 1'b0);
        get(o); chk_out(o, 1040, 1'b1);
    endtask
    // stalled sink: fill until refused, then drain in order
    task automatic t_fifo();
        cfg_wr(CFG_ADDR, 8'h00);
        stall <= 1'b1;
        @(negedge clk_in);
        n = 0;
        while (in_ready === 1'b1 && n < 40) begin
            u_odr_stream_partner.send(SAMPLE_W'(100 + n));
            n++;
        end
        u_odr_stream_partner.idle();
        chk_cfg(8'(n), 8'(FIFO_DEPTH + 1));
        stall <= 1'b0;
        for (int i = 0; i < n; i++) begin
            get(o); chk_out(o, 100 + i, 1'b0);
        end
    endtask
    // mid-run reset clears the config; then the advised setting, gain code 3 only
    task automatic t_reset();
        cfg_wr(CFG_ADDR, 8'h83);
        srst_in <= 1'b1;
        repeat (2) @(negedge clk_in);
        srst_in <= 1'b0;
        @(negedge clk_in);
        cfg_rd(CFG_ADDR, rv); chk_cfg(rv, CFG_RESET);
        u_odr_stream_partner.send(19'h003e8);
        u_odr_stream_partner.send(19'h0ea60);
        u_odr_stream_partner.idle();
        get(o); chk_out(o, 1000, 1'b0);
        get(o); chk_out(o, 60000, 1'b0);
        pair(8'h83, 1000, 1512, 1512, 1'b0);
        pair(8'h83, 1000, 1600, 1000, 1'b1);
    endtask
    initial begin
        repeat (8) @(negedge clk_in);
        srst_in <= 1'b0;
        @(negedge clk_in);
        t_cfg();
        t_off();
        t_gain();
        t_tc();
        t_order1();
        t_fifo();
        t_reset();
        final_report();
    end
    // watchdog against a hung handshake
    initial begin
        #1ms;
        failures++;
        $display("ERROR t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
        final_report();
    end
endmodule
